/* pout_pkg.sv */
// Shared constants and types for the pattern output enable and trigger block
package pout_pkg;
  localparam int DATA_W = 8;
  localparam int OUT_W = 16;
  localparam int GROUPS = 4;
  localparam int GRP_W = 4;
  localparam int CHANNELS = 4;
  localparam int SEL_W = 2;
  localparam int ADDR_W = 4;

  // Register indices (word offsets on the plain register port)
  localparam logic [ADDR_W-1:0] ADDR_LOW_ENABLE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_ENABLE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_TRIGGER_SEL = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_LOW_STAGED = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_HIGH_STAGED = 4'h4;
  localparam logic [ADDR_W-1:0] ADDR_PORT_LATCH = 4'h5;

  localparam logic [DATA_W-1:0] RST_ENABLE = 8'h00;
  localparam logic [DATA_W-1:0] RST_TRIGGER_SEL = 8'hFF;
  localparam logic [DATA_W-1:0] RST_STAGED = 8'h00;
  localparam logic [OUT_W-1:0] RST_PORT_LATCH = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] low_enable;
    logic [DATA_W-1:0] high_enable;
    logic [DATA_W-1:0] trigger_sel;
    logic [DATA_W-1:0] low_staged;
    logic [DATA_W-1:0] high_staged;
  } cfg_t;
endpackage

/* pout_group_trigger.sv */
// Picks one timer channel's compare-match pulse per output group
`timescale 1ns/1ps
module pout_group_trigger
  import pout_pkg::*;
(
  input wire logic [DATA_W-1:0] trigger_sel,
  input wire logic [CHANNELS-1:0] compare_match_a,
  output logic [GROUPS-1:0] group_fire
);
  // Field g at bits 2g+1:2g; code n selects channel n
  for (genvar g = 0; g < GROUPS; g++) begin : g_sel
    logic [SEL_W-1:0] chan;
    assign chan = trigger_sel[SEL_W*g +: SEL_W];
    assign group_fire[g] = compare_match_a[chan];
  end
endmodule

/* pout_transfer.sv */
// Per-bit gated copy of staged data into the port output latch
`timescale 1ns/1ps
module pout_transfer
  import pout_pkg::*;
(
  input wire logic [OUT_W-1:0] latch_cur,
  input wire logic [OUT_W-1:0] staged,
  input wire logic [OUT_W-1:0] enable,
  input wire logic [GROUPS-1:0] group_fire_d,
  output logic [OUT_W-1:0] latch_next
);
  for (genvar b = 0; b < OUT_W; b++) begin : g_bit
    // Enabled bits of a group move together on the same delayed pulse; disabled bits hold
    assign latch_next[b] = (group_fire_d[b / GRP_W] && enable[b])
                         ? staged[b]
                         : latch_cur[b];
  end
endmodule

/* pattern_output_unit.sv */
// Pattern output unit: transfer enables, group trigger select and output latch
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
module pattern_output_unit
  import pout_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic standby,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic [CHANNELS-1:0] compare_match_a,
  output logic [OUT_W-1:0] pattern_output_bits
);
  reg_req_t req;
  cfg_t cfg_reg;
  cfg_t cfg_next;
  logic [OUT_W-1:0] latch_reg;
  logic [OUT_W-1:0] latch_next;
  logic [OUT_W-1:0] xfer_value;
  logic [GROUPS-1:0] fire_reg;
  logic [GROUPS-1:0] fire_next;
  logic [GROUPS-1:0] group_fire;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [OUT_W-1:0] enable_all;
  logic [OUT_W-1:0] staged_all;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign enable_all = {cfg_reg.high_enable, cfg_reg.low_enable};
  assign staged_all = {cfg_reg.high_staged, cfg_reg.low_staged};

  ////////////////////////////////////////////////////////////////////////
  // Trigger selection and bit transfer

  pout_group_trigger u_trigger (
    .trigger_sel(cfg_reg.trigger_sel),
    .compare_match_a(compare_match_a),
    .group_fire(group_fire)
  );

  pout_transfer u_transfer (
    .latch_cur(latch_reg),
    .staged(staged_all),
    .enable(enable_all),
    .group_fire_d(fire_reg),
    .latch_next(xfer_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register file

  always_comb begin
    cfg_next = cfg_reg;
    // Standby is accepted but deliberately has no effect on stored state
    if (req.wr) begin
      case (req.addr)
        ADDR_LOW_ENABLE: cfg_next.low_enable = req.wdata;
        ADDR_HIGH_ENABLE: cfg_next.high_enable = req.wdata;
        ADDR_TRIGGER_SEL: cfg_next.trigger_sel = req.wdata;
        ADDR_LOW_STAGED: cfg_next.low_staged = req.wdata;
        ADDR_HIGH_STAGED: cfg_next.high_staged = req.wdata;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cfg_reg.low_enable <= RST_ENABLE;
      cfg_reg.high_enable <= RST_ENABLE;
      cfg_reg.trigger_sel <= RST_TRIGGER_SEL;
      cfg_reg.low_staged <= RST_STAGED;
      cfg_reg.high_staged <= RST_STAGED;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port output latch; the latch is read-only here, owned by transfers

  always_comb begin
    fire_next = group_fire;
    latch_next = xfer_value;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fire_reg <= '0;
      latch_reg <= RST_PORT_LATCH;
    end else begin
      fire_reg <= fire_next;
      latch_reg <= latch_next;
    end
  end

  assign pattern_output_bits = latch_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read port: data valid the cycle after the strobe only

  always_comb begin
    rdata_next = '0;
    if (req.rd) begin
      case (req.addr)
        ADDR_LOW_ENABLE: rdata_next = cfg_reg.low_enable;
        ADDR_HIGH_ENABLE: rdata_next = cfg_reg.high_enable;
        ADDR_TRIGGER_SEL: rdata_next = cfg_reg.trigger_sel;
        ADDR_LOW_STAGED: rdata_next = cfg_reg.low_staged;
        ADDR_HIGH_STAGED: rdata_next = cfg_reg.high_staged;
        ADDR_PORT_LATCH: rdata_next = latch_reg[DATA_W-1:0];
        default: rdata_next = UNMAPPED_READ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;
endmodule

/* pout_assertions.sv */
// Port-level checks of the pattern output unit
`timescale 1ns/1ps
module pout_checker
  import pout_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic [CHANNELS-1:0] compare_match_a,
  input wire logic [OUT_W-1:0] pattern_output_bits
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] m [5];
  wire [15:0] en = {m[1], m[0]};
  wire [15:0] st = {m[4], m[3]};
  // Mirror seeded with reset values, so reads right after reset are checked too
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      m <= '{8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
    end else if (reg_wr && reg_addr < 4'h5) begin
      m[reg_addr] <= reg_wdata;
    end
  end
  rd_back_a: assert property (reg_rd && reg_addr < 4'h5 |=>
    reg_rdata == $past(m[reg_addr])) else $error("readback");
  unmap_a: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  idle_rd_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("stray rdata");
  lat_rd_a: assert property (reg_rd && reg_addr == 4'h5 |=>
    reg_rdata == $past(pattern_output_bits[7:0])) else $error("latch read");
  mask_a: assert property (1'b1 |=> ((pattern_output_bits ^ $past(pattern_output_bits))
    & ~$past(en)) == 16'h0000) else $error("disabled bit moved");
  quiet_a: assert property ((compare_match_a == 4'h0) [*2] |=>
    $stable(pattern_output_bits)) else $error("change without match");
  grp3_a: assert property (compare_match_a[m[2][7:6]] && en[12] |-> ##2
    pattern_output_bits[12] == $past(st[12])) else $error("group 3 transfer");
  grp0_a: assert property (compare_match_a[m[2][1:0]] && en[0] |-> ##2
    pattern_output_bits[0] == $past(st[0])) else $error("group 0 transfer");
  cover property (compare_match_a[m[2][7:6]] && en[12]);
  cover property (reg_rd && reg_addr > 4'h5);
  cover property (reg_wr ##1 reg_rd);
endmodule
bind pattern_output_unit pout_checker chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .compare_match_a(compare_match_a),
  .pattern_output_bits(pattern_output_bits)
);

/* pout_timer_model.sv */
// Timer channels stand-in issuing compare-match A pulses
`timescale 1ns/1ps
module pout_timer_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [3:0] req,
  output logic [3:0] compare_match_a
);
  logic [3:0] cm_next;
  // One pulse per requested cycle; a held request gives back-to-back pulses
  always_comb cm_next = sys_rst ? 4'h0 : req;
  always_ff @(posedge core_clk) compare_match_a <= cm_next;
endmodule

/* pattern_output_unit_test.sv */
// Self-checking bench for the pattern output unit
`timescale 1ns/1ps
module pattern_output_unit_test
  import pout_pkg::*;
();
  logic core_clk = 1'b0, sys_rst = 1'b1, standby = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d;
  logic [3:0] reg_addr = 4'h0, req = 4'h0, cm, p1, p2;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, rnd = 8'h61, r [5], qr [$];
  logic [15:0] pat, ex, k, qp [$];
  int n_errors = 0, comparisons = 0, cyc = 0;
  pattern_output_unit DUT (.core_clk, .sys_rst, .standby, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .compare_match_a(cm), .pattern_output_bits(pat));
  pout_timer_model timer (.core_clk, .sys_rst, .req, .compare_match_a(cm));
  initial forever #25 core_clk = ~core_clk;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic results;
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic bus(input logic w, rd, input logic [3:0] a, p, input logic [7:0] d);
    {reg_wr, reg_rd, reg_addr, req, reg_wdata} <= {w, rd, a, p, d};
    @(posedge core_clk);
  endtask
  task automatic idle;
    bus(1'b0, 1'b0, 4'h0, 4'h0, 8'h00);
  endtask
  task automatic rd(input logic [3:0] a);
    qr.push_back(a < 4'h5 ? r[a] : a == 4'h5 ? ex[7:0] : 8'h00);
    bus(1'b0, 1'b1, a, 4'h0, 8'h00);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    if (a < 4'h5) r[a] = d;
    bus(1'b1, 1'b0, a, 4'h0, d);
  endtask
  task automatic pulse(input logic [3:0] p);
    for (int g = 0; g < 4; g++) begin
      k = {r[1], r[0]} & (16'h000F << 4 * g);
      if (p[r[2][2 * g +: 2]]) begin
        ex = ex & ~k | {r[4], r[3]} & k;
      end
    end
    qp.push_back(ex);
    bus(1'b0, 1'b0, 4'h0, p, 8'h00);
  endtask
  always @(posedge core_clk) begin
    rd_d <= reg_rd;
    p1 <= cm;
    p2 <= p1;
    cyc++;
    if (rd_d) check("reg_rdata", reg_rdata, qr.pop_front());
    if (|p2) check("pattern_output_bits", pat, qp.pop_front());
    if (cyc > 2000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    for (int n = 0; n < 2; n++) begin
      r = '{8'h00, 8'h00, RST_TRIGGER_SEL, 8'h00, 8'h00};
      ex = 16'h0000;
      sys_rst <= 1'b1;
      repeat (4) idle();
      sys_rst <= 1'b0;
      for (int a = 0; a < 8; a++) rd(4'(a));
      for (int i = 0; i < 4 && n == 0; i++) begin
        for (int a = 0; a < 6; a++) begin
          rnd = lfsr(rnd);
          wr(4'(a), a == 2 ? {2'(i + 3), 2'(i + 2), 2'(i + 1), 2'(i)} : rnd);
        end
        for (int c = 0; c < 4; c++) pulse(4'h1 << c);
        repeat (3) idle();
        // Standby flips after the writes, so the reads show state held across it
        standby <= i[0];
        for (int a = 0; a < 8; a++) rd(4'(a));
      end
    end
    repeat (2) idle();
    results();
  end
endmodule
